// file: ssa_top.sv
// register core, attenuation selector and bus slave of the second serial port
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module ssa_top (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic SEC_CS_B,
  input wire logic SEC_SCLK,
  output logic SEC_SDO_O,
  output logic SEC_SDO_OE,
  input wire logic SEC_SDIO_I,
  output logic SEC_SDIO_O,
  output logic SEC_SDIO_OE,
  input wire logic [18:0] GPIO_I,
  output logic [39:0] TX_ATTEN
);

  ssa_pkg::ssa_core_t c_q;
  ssa_pkg::ssa_core_t c_d;
  ssa_link_if lnk();
  logic pin_ok;
  logic [4:0] pin_idx;
  logic sel_level;
  logic ser_evt;
  logic [9:0] want;
  logic [31:0] old;
  logic [31:0] merged;
  logic [31:0] bmask;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [2:0] widx;

  // ------------------------------------------------------------
  // serial engine
  // ------------------------------------------------------------
  ssa_serial_port u_serial (
    .rst_n(RST_B),
    .sclk(SEC_SCLK),
    .cs_b(SEC_CS_B),
    .sdio_i(SEC_SDIO_I),
    .sdo_o(SEC_SDO_O),
    .sdo_oe(SEC_SDO_OE),
    .sdio_o(SEC_SDIO_O),
    .sdio_oe(SEC_SDIO_OE),
    .lnk(lnk)
  );

  // primary port settings are shared by the second port
  assign lnk.cfg = c_q.ctrl; // [R5]

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    c_d = c_q;
    old = 32'h0000_0000;
    merged = 32'h0000_0000;
    widx = 3'h0;
    want = 10'h000;
    wa = c_q.awaddr;
    ra = ARADDR;
    bmask = {{8{c_q.wstrb[3]}}, {8{c_q.wstrb[2]}}, {8{c_q.wstrb[1]}}, {8{c_q.wstrb[0]}}};

    // state pin: two stages before anything looks at it
    c_d.pin_m = GPIO_I[18:4]; // [R15]
    c_d.pin_s = c_q.pin_m; // [R15]
    pin_ok = (c_q.pin_sel >= ssa_pkg::PIN_MIN) && (c_q.pin_sel <= ssa_pkg::PIN_MAX); // [R10]
    pin_idx = 5'(c_q.pin_sel - ssa_pkg::PIN_MIN);
    sel_level = pin_ok ? c_q.pin_s[pin_idx[3:0]] : 1'b0; // [R9] [R10]

    // serial write event: toggle crosses through two flops, third finds the edge
    c_d.tgl = {c_q.tgl[1:0], lnk.wtoggle};
    ser_evt = c_q.tgl[2] ^ c_q.tgl[1];

    // ----------------------------------------------------------
    // bus write
    // ----------------------------------------------------------
    if (AWVALID && c_q.awready)
    begin
      c_d.aw_have = 1'b1;
      c_d.awaddr = AWADDR;
    end
    if (WVALID && c_q.wready)
    begin
      c_d.w_have = 1'b1;
      c_d.wdata = WDATA;
      c_d.wstrb = WSTRB;
    end
    if (c_q.bvalid && BREADY)
    begin
      c_d.bvalid = 1'b0;
    end
    if (c_q.aw_have && c_q.w_have && !c_q.bvalid)
    begin
      c_d.aw_have = 1'b0;
      c_d.w_have = 1'b0;
      c_d.bvalid = 1'b1;
      c_d.bresp = ssa_pkg::RESP_OKAY;
      if (wa == ssa_pkg::OFS_CTRL)
      begin
        old = {28'h0, c_q.ctrl};
        merged = (old & ~bmask) | (c_q.wdata & bmask);
        c_d.ctrl = merged[3:0]; // [R2]
      end
      else if (wa == ssa_pkg::OFS_PIN)
      begin
        old = {20'h0, c_q.mask, 3'h0, c_q.pin_sel};
        merged = (old & ~bmask) | (c_q.wdata & bmask);
        c_d.pin_sel = merged[ssa_pkg::PIN_SEL_LSB +: 5]; // [R9]
        c_d.mask = merged[ssa_pkg::PIN_MASK_LSB +: 4]; // [R11]
      end
      else if (wa == ssa_pkg::OFS_LATCH)
      begin
        old = {27'h0, c_q.latch};
        merged = (old & ~bmask) | (c_q.wdata & bmask);
        c_d.latch = merged[4:0]; // [R13] [R14]
      end
      else if (wa[7:5] == ssa_pkg::OFS_BANK[7:5] && wa[1:0] == 2'h0)
      begin
        widx = wa[4:2];
        old = {22'h0, c_q.bank[widx]};
        merged = (old & ~bmask) | (c_q.wdata & bmask);
        c_d.bank[widx] = merged[9:0]; // [R6]
      end
      else if (wa == ssa_pkg::OFS_STATUS || wa[7:4] == ssa_pkg::OFS_APPLIED[7:4])
      begin
        c_d.bresp = ssa_pkg::RESP_OKAY;
      end
      else
      begin
        c_d.bresp = ssa_pkg::RESP_SLVERR;
      end
    end

    // ----------------------------------------------------------
    // serial write, later than the bus so it wins a tie
    // ----------------------------------------------------------
    if (ser_evt && c_q.ctrl[ssa_pkg::CTRL_EN]) // [R1] [R2]
    begin
      if (lnk.waddr < ssa_pkg::SER_BANK_END)
      begin
        widx = lnk.waddr[3:1];
        if (lnk.waddr[0])
        begin
          c_d.stage[widx] = lnk.wdata[1:0]; // [R16]
        end
        else
        begin
          // the low byte commits the whole word, high bits from the staging pair
          c_d.bank[widx] = {c_q.stage[widx], lnk.wdata}; // [R6] [R16]
        end
      end
      else if (lnk.waddr == ssa_pkg::SER_LATCH)
      begin
        c_d.latch = lnk.wdata[4:0]; // [R13] [R14]
      end
    end

    // ----------------------------------------------------------
    // attenuation selection and update
    // ----------------------------------------------------------
    c_d.latch_prev = c_q.latch[4:1];
    for (int n = 0; n < ssa_pkg::NUM_TX; n++)
    begin
      // channels outside the mask stay on the first set whatever the pin does
      if (c_q.mask[n] && sel_level) // [R11] [R12]
      begin
        want = c_q.bank[ssa_pkg::NUM_TX + n]; // [R8]
      end
      else
      begin
        want = c_q.bank[n]; // [R7]
      end
      if (!c_q.latch[ssa_pkg::LATCH_MODE]) // [R13]
      begin
        c_d.applied[n] = want;
      end
      else if (c_q.latch[ssa_pkg::LATCH_TX_LSB + n] && !c_q.latch_prev[n]) // [R14]
      begin
        c_d.applied[n] = want;
      end
    end

    // ----------------------------------------------------------
    // bus read
    // ----------------------------------------------------------
    if (c_q.rvalid && RREADY)
    begin
      c_d.rvalid = 1'b0;
    end
    if (ARVALID && c_q.arready)
    begin
      c_d.rvalid = 1'b1;
      c_d.rresp = ssa_pkg::RESP_OKAY;
      c_d.rdata = 32'h0000_0000;
      if (ra == ssa_pkg::OFS_CTRL)
      begin
        c_d.rdata = {28'h0, c_q.ctrl};
      end
      else if (ra == ssa_pkg::OFS_PIN)
      begin
        c_d.rdata = {20'h0, c_q.mask, 3'h0, c_q.pin_sel};
      end
      else if (ra == ssa_pkg::OFS_LATCH)
      begin
        c_d.rdata = {27'h0, c_q.latch};
      end
      else if (ra == ssa_pkg::OFS_STATUS)
      begin
        c_d.rdata[ssa_pkg::STAT_LEVEL] = sel_level;
        c_d.rdata[ssa_pkg::STAT_PIN_OK] = pin_ok;
        c_d.rdata[ssa_pkg::STAT_EN] = c_q.ctrl[ssa_pkg::CTRL_EN];
      end
      else if (ra[7:4] == ssa_pkg::OFS_APPLIED[7:4] && ra[1:0] == 2'h0)
      begin
        c_d.rdata = {22'h0, c_q.applied[ra[3:2]]};
      end
      else if (ra[7:5] == ssa_pkg::OFS_BANK[7:5] && ra[1:0] == 2'h0)
      begin
        c_d.rdata = {22'h0, c_q.bank[ra[4:2]]};
      end
      else
      begin
        c_d.rresp = ssa_pkg::RESP_SLVERR;
      end
    end

    // one write and one read in flight; readies drop while an answer waits
    c_d.awready = !c_d.aw_have && !c_d.bvalid;
    c_d.wready = !c_d.w_have && !c_d.bvalid;
    c_d.arready = !c_d.rvalid;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      c_q <= '0;
      c_q.ctrl <= ssa_pkg::CTRL_RST;
      c_q.pin_sel <= ssa_pkg::PIN_SEL_RST;
      c_q.mask <= ssa_pkg::MASK_RST;
      c_q.latch <= ssa_pkg::LATCH_RST;
      c_q.bank <= {ssa_pkg::NUM_WORDS{ssa_pkg::ATTEN_RST}};
      c_q.applied <= {ssa_pkg::NUM_TX{ssa_pkg::ATTEN_RST}};
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign AWREADY = c_q.awready;
  assign WREADY = c_q.wready;
  assign BVALID = c_q.bvalid;
  assign BRESP = c_q.bresp;
  assign ARREADY = c_q.arready;
  assign RVALID = c_q.rvalid;
  assign RDATA = c_q.rdata;
  assign RRESP = c_q.rresp;
  assign TX_ATTEN = c_q.applied;

endmodule : ssa_top

// file: ssa_pkg.sv
// constants, types and helpers shared by the secondary serial port design
// Behaviour
// [R1] a second serial port, separate from the primary, writes attenuation settings
// [R2] the host turns the second port on by setting its enable to 1
// [R3] once enabled, the port's four pins take their serial directions automatically
// [R4] pin 3 chip select in, pin 2 clock in, pins 1 and 0 data by mode
// [R5] bit order, wire mode and single instruction follow the primary port settings
// [R6] two sets of four 10-bit transmit attenuation words, all serially writable
// [R7] state pin low applies the state one words to the transmitters
// [R8] state pin high applies the state two words to the transmitters
// [R9] the host picks one pin and toggles it to swap attenuation states
// [R10] only general pins 4 through 18 are accepted as the state pin
// [R11] a channel mask, one bit per transmitter, picks the pin-controlled channels
// [R12] an all-zero mask puts no transmitter under pin control
// [R13] update mode bit 0: 0 applies at once, 1 waits for latch bits
// [R14] latch bits 4..1 apply on a rising edge and must be cleared by host
// [R15] the state pin passes a two-stage synchroniser before it is used
// [R16] attenuation words sit in a bank reached by address-data serial transactions
package ssa_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_TX = 4;
  localparam int ATTEN_W = 10;
  localparam int NUM_WORDS = 8;
  localparam int NUM_PINS = 15;
  localparam int GPIO_W = 19;
  localparam int AXI_AW = 8;
  localparam int SER_AW = 15;

  // ------------------------------------------------------------
  // register bus offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PIN = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_APPLIED = 8'h10;
  localparam logic [7:0] OFS_BANK = 8'h20;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_LSB_FIRST = 1;
  localparam int CTRL_THREE_WIRE = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int PIN_SEL_LSB = 0;
  localparam int PIN_MASK_LSB = 8;
  localparam int LATCH_MODE = 0;
  localparam int LATCH_TX_LSB = 1;
  localparam int STAT_LEVEL = 0;
  localparam int STAT_PIN_OK = 1;
  localparam int STAT_EN = 2;
  localparam int INST_RD = 15;

  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [4:0] PIN_SEL_RST = 5'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [9:0] ATTEN_RST = 10'h000;
  localparam logic [4:0] PIN_MIN = 5'h04;
  localparam logic [4:0] PIN_MAX = 5'h12;

  // ------------------------------------------------------------
  // serial port map, framing and bus response codes
  // ------------------------------------------------------------
  localparam logic [14:0] SER_BANK_END = 15'h0010;
  localparam logic [14:0] SER_LATCH = 15'h002a;
  localparam logic [3:0] INST_LAST = 4'hf;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cfg_m;
    logic [3:0] cfg_s;
    logic [14:0] waddr;
    logic [7:0] wdata;
    logic wtgl;
  } ssa_hold_t;

  typedef struct packed {
    logic inst_done;
    logic [3:0] cnt;
    logic [14:0] sh;
    logic rd;
    logic [14:0] addr;
    logic stop;
    logic sdo_oe;
    logic sdio_oe;
    logic dout;
  } ssa_frame_t;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [4:0] pin_sel;
    logic [3:0] mask;
    logic [4:0] latch;
    logic [3:0] latch_prev;
    logic [7:0][9:0] bank;
    logic [7:0][1:0] stage;
    logic [3:0][9:0] applied;
    logic [14:0] pin_m;
    logic [14:0] pin_s;
    logic [2:0] tgl;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssa_core_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

endpackage : ssa_pkg

// file: ssa_link_if.sv
// carrier between the serial engine and the register core
`timescale 1ns/10ps
interface ssa_link_if;
  logic [14:0] waddr;
  logic [7:0] wdata;
  logic wtoggle;
  logic [3:0] cfg;
  modport port (output waddr, output wdata, output wtoggle, input cfg);
  modport core (input waddr, input wdata, input wtoggle, output cfg);
endinterface : ssa_link_if

// file: ssa_serial_port.sv
// serial engine of the second port, clocked by the host's serial clock
`timescale 1ns/10ps
module ssa_serial_port (
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdio_i,
  output logic sdo_o,
  output logic sdo_oe,
  output logic sdio_o,
  output logic sdio_oe,
  ssa_link_if.port lnk
);

  ssa_pkg::ssa_hold_t h_q;
  ssa_pkg::ssa_hold_t h_d;
  ssa_pkg::ssa_frame_t f_q;
  ssa_pkg::ssa_frame_t f_d;
  logic frame_rst_n;
  logic en;
  logic lsb_first;
  logic three_wire;
  logic single;
  logic [15:0] word;
  logic [15:0] inst;
  logic [7:0] dbyte;

  // ------------------------------------------------------------
  // frame state
  // ------------------------------------------------------------
  // the clock stands still outside frames, so chip select high clears the frame
  assign frame_rst_n = rst_n & ~cs_b;

  always_comb
  begin
    h_d = h_q;
    f_d = f_q;
    h_d.cfg_m = lnk.cfg;
    h_d.cfg_s = h_q.cfg_m;
    en = h_q.cfg_s[ssa_pkg::CTRL_EN]; // [R2]
    lsb_first = h_q.cfg_s[ssa_pkg::CTRL_LSB_FIRST]; // [R5]
    three_wire = h_q.cfg_s[ssa_pkg::CTRL_THREE_WIRE]; // [R5]
    single = h_q.cfg_s[ssa_pkg::CTRL_SINGLE]; // [R5]
    word = {f_q.sh, sdio_i};
    inst = lsb_first ? ssa_pkg::rev16(word) : word;
    dbyte = lsb_first ? ssa_pkg::rev8(word[7:0]) : word[7:0];
    f_d.dout = 1'b0;
    // the clock only runs inside frames, so the settings cross in the first two edges;
    // the enable is looked at once the instruction is in, and must not move mid-frame
    if (!f_q.stop)
    begin
      f_d.sh = word[14:0];
      f_d.cnt = 4'(f_q.cnt + 4'h1);
      if (!f_q.inst_done)
      begin
        if (f_q.cnt == ssa_pkg::INST_LAST) // [R16]
        begin
          f_d.inst_done = 1'b1;
          f_d.cnt = 4'h0;
          f_d.rd = inst[ssa_pkg::INST_RD];
          f_d.addr = inst[14:0];
          f_d.stop = ~en; // [R2]
          f_d.sdo_oe = en & inst[ssa_pkg::INST_RD] & ~three_wire; // [R3] [R4]
          f_d.sdio_oe = en & inst[ssa_pkg::INST_RD] & three_wire; // [R3] [R4]
        end
      end
      else if (f_q.cnt == ssa_pkg::DATA_LAST)
      begin
        f_d.cnt = 4'h0;
        f_d.addr = 15'(f_q.addr + 15'h0001);
        if (!f_q.rd) // [R1]
        begin
          h_d.waddr = f_q.addr;
          h_d.wdata = dbyte;
          h_d.wtgl = ~h_q.wtgl;
        end
        if (single) // [R5]
        begin
          f_d.stop = 1'b1;
          f_d.sdo_oe = 1'b0;
          f_d.sdio_oe = 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // hold state survives chip select so a word is not lost while it crosses
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      h_q <= '0;
    else
      h_q <= h_d;
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  assign lnk.waddr = h_q.waddr;
  assign lnk.wdata = h_q.wdata;
  assign lnk.wtoggle = h_q.wtgl;
  assign sdo_o = f_q.dout;
  assign sdio_o = f_q.dout;
  assign sdo_oe = f_q.sdo_oe;
  assign sdio_oe = f_q.sdio_oe;

endmodule : ssa_serial_port

// file: ssa_top_checker.sv
// concurrent checks on the ports of the second serial port top
`timescale 1ns/10ps
module ssa_top_checker (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic SEC_CS_B,
  input wire logic SEC_SDO_OE,
  input wire logic SEC_SDIO_OE,
  input wire logic [18:0] GPIO_I,
  input wire logic [39:0] TX_ATTEN
);
  // ------------------------------------------------------------
  // quiet counters: cycles since the last write cause and pin change
  // ------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [3:0] gq_q;
  logic [18:0] gp_q;
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt_q <= 4'h0;
      gq_q <= 4'h0;
      gp_q <= 19'h00000;
    end
    else
    begin
      cnt_q <= (!SEC_CS_B || (AWVALID && AWREADY)) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
      gq_q <= (GPIO_I != gp_q) ? 4'h0 : gq_q + {3'h0, gq_q != 4'hf};
      gp_q <= GPIO_I;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_bus_calm;
    cnt_q > 4'h7;
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_tx_idle_hold: assert property (s_bus_calm and gq_q > 4'h7 |-> $stable(TX_ATTEN))
    else $error("applied attenuation moved with no cause");
  chk_pin_two_stage: assert property (s_bus_calm and GPIO_I != gp_q |=> $stable(TX_ATTEN))
    else $error("state pin reached the transmitters too fast");
  chk_write_answer: assert property (s_wr_taken |-> ##2 BVALID)
    else $error("write response late");
  chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  chk_one_write: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("second write accepted while one pending");
  chk_oe_idle: assert property (SEC_CS_B && $past(SEC_CS_B) |-> !SEC_SDO_OE && !SEC_SDIO_OE)
    else $error("data pin driven outside a frame");
  chk_oe_one_pin: assert property (!(SEC_SDO_OE && SEC_SDIO_OE))
    else $error("both data pins driven");
endmodule : ssa_top_checker
bind ssa_top ssa_top_checker u_chk (.MCLK(MCLK), .RST_B(RST_B), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RREADY(RREADY), .SEC_CS_B(SEC_CS_B), .SEC_SDO_OE(SEC_SDO_OE), .SEC_SDIO_OE(SEC_SDIO_OE),
  .GPIO_I(GPIO_I), .TX_ATTEN(TX_ATTEN));

// file: ssa_host_model.sv
// host serial controller that writes one byte per frame
`timescale 1ns/10ps
module ssa_host_model (
  output logic sclk,
  output logic cs_b,
  output logic sdio_h
);
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdio_h = 1'b0;
  end
  // clock stands still between frames; hp sets half period, so slow hosts work too
  task automatic send(input logic [14:0] adr, input logic [7:0] dat, input logic lsb,
    input int hp);
    logic [23:0] bits;
    bits = {1'b0, adr, dat};
    if (lsb)
    begin
      bits[23:8] = {<<{bits[23:8]}};
      bits[7:0] = {<<{bits[7:0]}};
    end
    #7;
    cs_b = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdio_h = bits[i];
      #(hp);
      sclk = 1'b1;
      #(hp);
      sclk = 1'b0;
    end
    #9;
    cs_b = 1'b1;
    // released line shows the inverse so a stale bit is never mistaken for data
    sdio_h = ~sdio_h;
    #300;
  endtask : send
endmodule : ssa_host_model

// file: secondary_spi_tx_atten_select_tb.sv
// self-checking bench for the second serial port top
`timescale 1ns/10ps
module secondary_spi_tx_atten_select_tb;
  logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sdo_o, sdo_oe, sdio_o, sdio_oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [18:0] gpio;
  logic [39:0] tx;
  logic sclk, cs_b, sdio_h;
  wire logic sdio_i = sdio_oe ? sdio_o : sdio_h;
  int errors, comparisons, cycles;
  integer seed = 32'hee0a;
  logic [33:0] notes[$];
  logic [9:0] s1[4], s2[4];
  int pins[4] = '{3, 4, 18, 19};
  ssa_top uut (.MCLK(mclk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .SEC_CS_B(cs_b), .SEC_SCLK(sclk), .SEC_SDO_O(sdo_o), .SEC_SDO_OE(sdo_oe),
    .SEC_SDIO_I(sdio_i), .SEC_SDIO_O(sdio_o), .SEC_SDIO_OE(sdio_oe), .GPIO_I(gpio),
    .TX_ATTEN(tx));
  ssa_host_model host (.sclk(sclk), .cs_b(cs_b), .sdio_h(sdio_h));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // checking, bus tasks and closing
  // ------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("BAD %0t run hung", $time);
      close_out();
    end
  end
  // read results are matched against the oldest note, on the settled values of the
  // falling edge that precede the handshake edge
  always @(negedge mclk)
    if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0)
      chk(40'({rresp, rdata}), 40'(notes.pop_front()));
  // handshakes are judged at the falling edge, so a ready launched by the rising edge
  // is never mistaken for the one that edge sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs;
    logic w_hs;
    logic b_hs = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs)
    begin
      @(negedge mclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      @(posedge mclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ar_hs;
    logic r_hs = 1'b0;
    notes.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs)
    begin
      @(negedge mclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      @(posedge mclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic ser(input logic [14:0] a, input logic [7:0] d, input logic lsb, input int hp);
    host.send(a, d, lsb, hp);
    @(posedge mclk);
  endtask : ser
  function automatic logic [39:0] tx_exp(input logic lvl, input logic [3:0] m);
    logic [39:0] v;
    for (int n = 0; n < 4; n++) v[10*n +: 10] = (lvl && m[n]) ? s2[n] : s1[n];
    return v;
  endfunction : tx_exp
  // settle covers the two-stage pin sync and the serial crossing
  task automatic tx_is(input logic lvl, input logic [3:0] m);
    repeat (10) @(posedge mclk);
    chk(tx, tx_exp(lvl, m));
  endtask : tx_is
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, gpio} = 67'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 34'h0);
    rd(8'h04, 34'h0);
    rd(8'h08, 34'h0);
    rd(8'h80, {2'h2, 32'h0});
    for (int n = 0; n < 4; n++) s1[n] = 10'h000;
    for (int n = 0; n < 4; n++) s2[n] = 10'h000;
    tx_is(1'b0, 4'h0);
    $display("reset test done");
    for (int n = 0; n < 4; n++)
    begin
      s1[n] = 10'($random(seed));
      s2[n] = 10'($random(seed));
      wr(8'(8'h20 + 4 * n), {22'h0, s1[n]});
      wr(8'(8'h30 + 4 * n), {22'h0, s2[n]});
      rd(8'(8'h20 + 4 * n), {24'h0, s1[n]});
      rd(8'(8'h30 + 4 * n), {24'h0, s2[n]});
    end
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h00000f05);
    gpio <= 19'($random(seed)) & ~19'h00020;
    tx_is(1'b0, 4'hf);
    gpio <= 19'h7ffff;
    tx_is(1'b1, 4'hf);
    rd(8'h10, {24'h0, s2[0]});
    rd(8'h0c, 34'h7);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, {24'h00000f, 3'h0, 5'(pins[i])});
      tx_is(pins[i] >= 4 && pins[i] <= 18, 4'hf);
    end
    wr(8'h04, 32'h00000505);
    tx_is(1'b1, 4'h5);
    wr(8'h04, 32'h00000005);
    tx_is(1'b1, 4'h0);
    $display("selector test done");
    wr(8'h04, 32'h00000f05);
    s2[0] = 10'h25a;
    ser(15'h0009, 8'h02, 1'b0, 16);
    ser(15'h0008, 8'h5a, 1'b0, 16);
    tx_is(1'b1, 4'hf);
    // lsb first, three wire and single instruction together
    wr(8'h00, 32'hf);
    s2[1] = 10'h1c3;
    ser(15'h000b, 8'h01, 1'b1, 16);
    ser(15'h000a, 8'hc3, 1'b1, 16);
    tx_is(1'b1, 4'hf);
    wr(8'h00, 32'h0);
    ser(15'h0008, 8'h11, 1'b0, 16);
    rd(8'h30, {24'h0, s2[0]});
    $display("serial test done");
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h1);
    wr(8'h30, 32'h0000033c);
    gpio <= 19'h00000;
    tx_is(1'b1, 4'hf);
    // pin is low now, so the latch takes the state one word for tx0
    wr(8'h08, 32'h3);
    repeat (10) @(posedge mclk);
    chk(tx, {s2[3], s2[2], s2[1], s1[0]});
    rd(8'h08, 34'h3);
    // a bit left high gives no second edge
    gpio <= 19'h7ffff;
    wr(8'h08, 32'h3);
    repeat (10) @(posedge mclk);
    chk(tx, {s2[3], s2[2], s2[1], s1[0]});
    ser(15'h002a, 8'h01, 1'b0, 16);
    wr(8'h08, 32'h3);
    repeat (10) @(posedge mclk);
    chk(tx, {s2[3], s2[2], s2[1], 10'h33c});
    $display("latch test done");
    close_out();
  end
endmodule : secondary_spi_tx_atten_select_tb
